// *** bench/tb_mtr_relay.sv ***
// Self-checking testbench of the motor thermal overload relay
`timescale 1ns/1ps
`include "mtr_cfg.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_mtr_relay;
    import mtr_pkg::*;
    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic clk = 0, rst = 1, wr = 0, rd = 0, frst = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    mtr_word_t cur = 16'h0000, temp = 16'h0000;
    logic [3:0] tin = 4'h0;
    logic [1:0] tout;
    logic gate, mtrip, ttrip, pre, zone, irq;
    int n_errors = 0, total_checks = 0;
    logic [31:0] d;

    // Short tick keeps heat builds within a few thousand cycles
    mtr_relay #(.TICK_CYC(16)) dut_u (.ref_clk_in(clk), .rst_in(rst), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cur_in(cur),
        .temp_in(temp), .term_in(tin), .fault_reset_in(frst), .term_out(tout),
        .gate_enable_out(gate), .motor_overload_trip_out(mtrip),
        .transistor_overload_trip_out(ttrip), .thermal_prealarm_display_out(pre),
        .overload_zone_out(zone), .irq_out(irq));

    // 250 MHz clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus, wait and closing tasks
    // ------------------------------------------------------------
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rreg

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    function automatic logic sel(input int w);
        case (w)
            0: return pre;
            1: return mtrip;
            default: return ttrip;
        endcase
    endfunction : sel

    // Bounded wait so a stuck output cannot hang the run
    task automatic wait_on(input int w, input logic v);
        int n;
        n = 0;
        while (sel(w) !== v && n < 6000)
        begin
            cyc(1);
            n++;
        end
        `CHK(sel(w), v)
    endtask : wait_on

    // Pin pulse passes a two-flop synchroniser, so hold it a few cycles
    task automatic clr();
        cur <= 16'h0000; temp <= 16'h0000;
        @(posedge clk) frst <= 1'b1;
        cyc(5);
        @(posedge clk) frst <= 1'b0;
        cyc(5);
    endtask : clr

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rreg(`MTR_A_M1_RATED, d); `CHK(d, 32'h0000_0000)
        rreg(`MTR_A_M2_RATED, d); `CHK(d, 32'h0000_270F)
        rreg(`MTR_A_M2_TYPE, d); `CHK(d, 32'h0000_270F)
        rreg(`MTR_A_TEMP_LIMIT, d); `CHK(d, 32'h0000_0C80)
        rreg(8'h30, d); `CHK(d, 32'h0000_0000)
        rreg(`MTR_A_STATUS, d); `CHK(d, 32'h0000_0008)
        rreg(`MTR_A_HEAT1, d); `CHK(d, 32'h0000_0000)
        wreg(`MTR_A_IRQ_MASK, 32'h0000_0001);
        $display("test reset done");
    endtask : t_reset

    // Motor 1 off, transistor protection and derating by switching frequency
    task automatic t_xtor();
        cur <= 16'd80; temp <= 16'h0C7F;
        cyc(40);
        `CHK(zone, 1'b1)
        `CHK(ttrip, 1'b0)
        `CHK(mtrip, 1'b0)
        rreg(`MTR_A_STATUS, d); `CHK(d[7:6], 2'b00)
        wreg(`MTR_A_IN_FUNC, 32'h0000_0003);
        tin <= 4'h1;
        cyc(6);
        rreg(`MTR_A_STATUS, d); `CHK(d[7:4], 4'b0011)
        cur <= 16'd70;
        cyc(3);
        `CHK(zone, 1'b0)
        // PM motor: zone is judged against the zero motor rating
        wreg(`MTR_A_MOTOR_CFG, 32'h0000_0001);
        cyc(3);
        `CHK(zone, 1'b1)
        wreg(`MTR_A_MOTOR_CFG, 32'h0000_0002);
        wait_on(2, 1'b1);
        cyc(2);
        `CHK(gate, 1'b0)
        `CHK(irq, 1'b0)
        tin <= 4'h0;
        wreg(`MTR_A_MOTOR_CFG, 32'h0000_0000);
        clr();
        `CHK(gate, 1'b1)
        $display("test transistor done");
    endtask : t_xtor

    // Tracking motor 1 through prealarm to trip, interrupt and fault reset
    task automatic t_track();
        wreg(`MTR_A_OUT_FUNC, 32'h0000_6C08);
        wreg(`MTR_A_M1_RATED, 32'h0000_002C);
        rreg(`MTR_A_IRQ_STAT, d);
        cyc(2);
        `CHK(tout, 2'b10)
        cur <= 16'd80;
        wait_on(0, 1'b1);
        `CHK(mtrip, 1'b0)
        `CHK(gate, 1'b1)
        cyc(2);
        `CHK(tout, 2'b01)
        wait_on(1, 1'b1);
        cyc(3);
        `CHK(gate, 1'b0)
        `CHK(irq, 1'b1)
        rreg(`MTR_A_IRQ_STAT, d); `CHK(d[0], 1'b1)
        cyc(3);
        `CHK(irq, 1'b0)
        // Full heat of this rating lies above the unread low 16 bits
        rreg(`MTR_A_HEAT1, d); `CHK((d >= 32'h0000_0001), 1'b1)
        clr();
        `CHK(mtrip, 1'b0)
        `CHK(pre, 1'b0)
        rreg(`MTR_A_HEAT1, d); `CHK(d, 32'h0000_0000)
        $display("test track done");
    endtask : t_track

    // Second function select: state swap, cooling and second rating
    task automatic t_second();
        wreg(`MTR_A_IN_FUNC, 32'h0000_0003);
        wreg(`MTR_A_M2_RATED, 32'h0000_0064);
        rreg(`MTR_A_STATUS, d); `CHK(d[9:6], 4'b0110)
        cur <= 16'd45;
        wait_on(0, 1'b1);
        tin <= 4'h1;
        cyc(5);
        rreg(`MTR_A_STATUS, d); `CHK(d[9:4], 6'b100101)
        wait_on(0, 1'b0);
        `CHK(mtrip, 1'b0)
        wreg(`MTR_A_M2_RATED, 32'h0000_000A);
        cur <= 16'd20;
        wait_on(1, 1'b1);
        tin <= 4'h0;
        clr();
        $display("test second done");
    endtask : t_second

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        cyc(3);
        t_reset();
        t_xtor();
        t_track();
        t_second();
        end_sim();
    end

    // Whole run is about ten microseconds; allow ample margin
    initial
    begin
        #400000;
        n_errors++;
        end_sim();
    end
endmodule : tb_mtr_relay

// *** design/mtr_cfg.svh ***
// Register offsets, reset values and timing constants of the motor thermal relay
`ifndef MTR_CFG_SVH
`define MTR_CFG_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MTR_A_M1_RATED 8'h00
`define MTR_A_M2_RATED 8'h04
`define MTR_A_M2_TYPE 8'h08
`define MTR_A_MOTOR_CFG 8'h0C
`define MTR_A_IN_FUNC 8'h10
`define MTR_A_OUT_FUNC 8'h14
`define MTR_A_TEMP_LIMIT 8'h18
`define MTR_A_STATUS 8'h1C
`define MTR_A_HEAT1 8'h20
`define MTR_A_HEAT2 8'h24
`define MTR_A_IRQ_STAT 8'h28
`define MTR_A_IRQ_MASK 8'h2C
// ----------------------------------------------------------------
// Values and field positions
// ----------------------------------------------------------------
`define MTR_UNSET 16'h270F
`define MTR_M2_MAX 16'h1388
`define MTR_FN_RT 8'h03
`define MTR_FN_PRE_POS 8'h08
`define MTR_FN_PRE_NEG 8'h6C
`define MTR_RST_M1 16'h0000
`define MTR_RST_TEMP 16'h0C80
`define MTR_PRE_PCT 8'h55
`define MTR_FULL_PCT 8'h64
`define MTR_HEAT_SHIFT 6
`define MTR_DERATE 16'h0040
`define MTR_IRQ_MTRIP 0
`define MTR_IRQ_TTRIP 1
`define MTR_IRQ_PRE 2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MTR_CLK_MHZ 250
`define MTR_TICK_US 1000
`define MTR_TICK_CYC (`MTR_TICK_US * `MTR_CLK_MHZ)
`endif

// *** design/mtr_pkg.sv ***
// Types shared by the motor thermal relay
package mtr_pkg;
    typedef enum logic [1:0] {MTR_OFF, MTR_COOL, MTR_TRACK} mtr_state_e;
    typedef logic [15:0] mtr_word_t;
endpackage : mtr_pkg

// *** design/mtr_relay.sv ***
// Electronic motor thermal overload relay with transistor overload protection
`timescale 1ns/1ps
`include "mtr_cfg.svh"

module mtr_relay #(
    parameter int NIN = 4,
    parameter int NOUT = 2,
    parameter int TICK_CYC = `MTR_TICK_CYC,
    parameter logic [15:0] INV_RATED = 16'h0032
)(
    input wire logic ref_clk_in, // 250 MHz clock
    input wire logic rst_in, // Sync reset, high
    input wire logic [7:0] addr_in, // Register byte address
    input wire logic [31:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    output logic [31:0] rdata_out, // Read data, next cycle
    input wire mtr_pkg::mtr_word_t cur_in, // Output current, 0.1 A units
    input wire mtr_pkg::mtr_word_t temp_in, // Heat sink temperature code
    input wire logic [NIN-1:0] term_in, // Input terminal pins
    input wire logic fault_reset_in, // Reset input pin
    output logic [NOUT-1:0] term_out, // Output terminal pins
    output logic gate_enable_out, // Output transistor enable
    output logic motor_overload_trip_out, // Motor thermal trip
    output logic transistor_overload_trip_out, // Transistor thermal trip
    output logic thermal_prealarm_display_out, // Prealarm indicator
    output logic overload_zone_out, // Load above 150 percent
    output logic irq_out // Level interrupt
);
    import mtr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Terminal function code of terminal k in a packed word
    function automatic logic [7:0] fn_code(input logic [31:0] w, input int k);
        fn_code = w[8*k +: 8];
    endfunction : fn_code

    // Heat step: hold when off, else leak toward zero and add current squared when tracking
    function automatic logic [47:0] heat_step(input logic [47:0] h,
        input mtr_state_e s, input logic [31:0] isq);
        logic [47:0] leak;
        leak = h >> `MTR_HEAT_SHIFT;
        if (leak == 48'h0000_0000_0000 && h != 48'h0000_0000_0000)
            leak = 48'h0000_0000_0001;
        heat_step = h - leak;
        if (s == MTR_TRACK)
            heat_step = heat_step + {16'h0000, isq};
        else if (s == MTR_OFF)
            heat_step = h;
    endfunction : heat_step

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] m1_rated_r, m2_rated_r, m2_type_r, temp_limit_r;
    logic [3:0] motor_cfg_r; // bit0 PM motor, bits 3:1 switching freq
    logic [31:0] in_func_r, out_func_r;
    logic [2:0] irq_stat_r, irq_mask_r, irq_set;
    logic [47:0] heat1_r, heat2_r;
    logic mtrip_r, ttrip_r, pre_r;

    // Software writes
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            m1_rated_r <= `MTR_RST_M1;
            m2_rated_r <= `MTR_UNSET;
            m2_type_r <= `MTR_UNSET;
            motor_cfg_r <= 4'h0;
            in_func_r <= 32'h0000_0000;
            out_func_r <= 32'h0000_0000;
            temp_limit_r <= `MTR_RST_TEMP;
            irq_mask_r <= 3'h0;
        end
        else if (wr_in)
        begin
            case (addr_in)
                `MTR_A_M1_RATED: m1_rated_r <= wdata_in[15:0];
                `MTR_A_M2_RATED: m2_rated_r <= wdata_in[15:0];
                `MTR_A_M2_TYPE: m2_type_r <= wdata_in[15:0];
                `MTR_A_MOTOR_CFG: motor_cfg_r <= wdata_in[3:0];
                `MTR_A_IN_FUNC: in_func_r <= wdata_in;
                `MTR_A_OUT_FUNC: out_func_r <= wdata_in;
                `MTR_A_TEMP_LIMIT: temp_limit_r <= wdata_in[15:0];
                `MTR_A_IRQ_MASK: irq_mask_r <= wdata_in[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NIN-1:0] term_s1_r, term_s2_r;
    logic frst_s1_r, frst_s2_r;

    // Two flops per pin; stage one feeds stage two only
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            term_s1_r <= '0;
            term_s2_r <= '0;
            frst_s1_r <= 1'b0;
            frst_s2_r <= 1'b0;
        end
        else
        begin
            term_s1_r <= term_in;
            term_s2_r <= term_s1_r;
            frst_s1_r <= fault_reset_in;
            frst_s2_r <= frst_s1_r;
        end
    end

    // Select is the OR of every input terminal assigned to it
    logic [NIN-1:0] rt_hit;
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++)
        begin : g_in
            assign rt_hit[gi] = term_s2_r[gi] && fn_code(in_func_r, gi) == `MTR_FN_RT;
        end
    endgenerate
    logic rt;
    assign rt = |rt_hit;

    // ------------------------------------------------------------
    // Motor state selection
    // ------------------------------------------------------------
    logic m1_on, m2_range, m2_alias;
    mtr_state_e m1_state, m2_state;
    logic [15:0] m2_ref;
    assign m1_on = m1_rated_r != 16'h0000;
    assign m2_range = m2_rated_r != 16'h0000 && m2_rated_r <= `MTR_M2_MAX;
    // Unset motor 2 rating with a second motor type borrows motor 1 rating
    assign m2_alias = m2_rated_r == `MTR_UNSET && m2_type_r != `MTR_UNSET && m1_on;
    assign m2_ref = m2_range ? m2_rated_r : m1_rated_r;

    always_comb
    begin
        m1_state = MTR_OFF;
        if (m1_on)
        begin
            if (rt && (m2_range || m2_rated_r == 16'h0000 || m2_type_r != `MTR_UNSET))
                m1_state = MTR_COOL;
            else
                m1_state = MTR_TRACK;
        end
        m2_state = MTR_OFF;
        if (m2_range || m2_alias)
            m2_state = rt ? MTR_TRACK : MTR_COOL;
    end

    // ------------------------------------------------------------
    // Heat accumulation
    // ------------------------------------------------------------
    logic [$clog2(TICK_CYC)-1:0] tick_cnt_r;
    logic tick_r;
    // Slow heat tick; one-cycle enable
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || tick_cnt_r == ($clog2(TICK_CYC))'(TICK_CYC - 1))
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
        tick_r <= !rst_in && tick_cnt_r == ($clog2(TICK_CYC))'(TICK_CYC - 1);
    end

    logic [31:0] isq;
    assign isq = cur_in * cur_in;

    // Heat state; fault reset wins over a tick
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || frst_s2_r)
        begin
            heat1_r <= 48'h0000_0000_0000;
            heat2_r <= 48'h0000_0000_0000;
        end
        else if (tick_r)
        begin
            heat1_r <= heat_step(heat1_r, m1_state, isq);
            heat2_r <= heat_step(heat2_r, m2_state, isq);
        end
    end

    // ------------------------------------------------------------
    // Thresholds
    // ------------------------------------------------------------
    // Full heat is rating squared scaled like steady-state heat
    logic [47:0] full1, full2, h1x, h2x, p1, p2, f1, f2;
    logic pre_hit, trip_hit, temp_hit, zone_hit;
    // Widen before squaring; a product inside a concatenation keeps only 16 bits
    assign full1 = {16'h0000, 32'(m1_rated_r) * m1_rated_r} << `MTR_HEAT_SHIFT;
    assign full2 = {16'h0000, 32'(m2_ref) * m2_ref} << `MTR_HEAT_SHIFT;
    // Compare scaled by 100 to avoid a divider
    assign h1x = 48'(heat1_r * `MTR_FULL_PCT);
    assign h2x = 48'(heat2_r * `MTR_FULL_PCT);
    assign p1 = 48'(full1 * `MTR_PRE_PCT);
    assign p2 = 48'(full2 * `MTR_PRE_PCT);
    assign f1 = 48'(full1 * `MTR_FULL_PCT);
    assign f2 = 48'(full2 * `MTR_FULL_PCT);
    assign pre_hit = (m1_state != MTR_OFF && h1x >= p1)
        || (m2_state != MTR_OFF && h2x >= p2);
    // Only a tracking motor can reach full heat and trip
    assign trip_hit = (m1_state == MTR_TRACK && h1x >= f1)
        || (m2_state == MTR_TRACK && h2x >= f2);

    // Trip point drops as the switching frequency code rises
    logic [15:0] derate, temp_thr, load_ref;
    assign derate = 16'(motor_cfg_r[3:1] * `MTR_DERATE);
    assign temp_thr = (temp_limit_r > derate) ? temp_limit_r - derate : 16'h0000;
    assign temp_hit = temp_in >= temp_thr;

    // Load reference: inverter rating for induction, motor rating for PM
    assign load_ref = motor_cfg_r[0] ? (rt ? m2_ref : m1_rated_r) : INV_RATED;
    assign zone_hit = {1'b0, cur_in, 1'b0} > {1'b0, load_ref, 1'b0} + {2'b00, load_ref};

    // ------------------------------------------------------------
    // Trips and prealarm
    // ------------------------------------------------------------
    // Trips latch until fault reset
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || frst_s2_r)
        begin
            mtrip_r <= 1'b0;
            ttrip_r <= 1'b0;
            pre_r <= 1'b0;
        end
        else
        begin
            mtrip_r <= mtrip_r || trip_hit;
            ttrip_r <= ttrip_r || temp_hit;
            pre_r <= pre_hit;
        end
    end

    logic [NOUT-1:0] term_r;
    logic gate_r, zone_r;
    // Gate removal one cycle after any trip latches
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            gate_r <= 1'b0;
            zone_r <= 1'b0;
        end
        else
        begin
            gate_r <= !(mtrip_r || ttrip_r);
            zone_r <= zone_hit;
        end
    end

    // Output terminal routing; unassigned codes drive low
    generate
        for (gi = 0; gi < NOUT; gi++)
        begin : g_out
            always_ff @(posedge ref_clk_in)
            begin
                if (rst_in)
                    term_r[gi] <= 1'b0;
                else if (fn_code(out_func_r, gi) == `MTR_FN_PRE_POS)
                    term_r[gi] <= pre_r;
                else if (fn_code(out_func_r, gi) == `MTR_FN_PRE_NEG)
                    term_r[gi] <= !pre_r;
                else
                    term_r[gi] <= 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupts and read port
    // ------------------------------------------------------------
    logic mtrip_d_r, ttrip_d_r, pre_d_r, irq_r;
    logic [31:0] rdata_r;
    assign irq_set = {pre_r && !pre_d_r, ttrip_r && !ttrip_d_r, mtrip_r && !mtrip_d_r};

    // Sticky bits; a new event beats the clear-on-read
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            irq_stat_r <= 3'h0;
            {mtrip_d_r, ttrip_d_r, pre_d_r} <= 3'h0;
            irq_r <= 1'b0;
        end
        else
        begin
            if (rd_in && addr_in == `MTR_A_IRQ_STAT)
                irq_stat_r <= irq_set;
            else
                irq_stat_r <= irq_stat_r | irq_set;
            {mtrip_d_r, ttrip_d_r, pre_d_r} <= {mtrip_r, ttrip_r, pre_r};
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Read data for one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || !rd_in)
            rdata_r <= 32'h0000_0000;
        else
        begin
            case (addr_in)
                `MTR_A_M1_RATED: rdata_r <= {16'h0000, m1_rated_r};
                `MTR_A_M2_RATED: rdata_r <= {16'h0000, m2_rated_r};
                `MTR_A_M2_TYPE: rdata_r <= {16'h0000, m2_type_r};
                `MTR_A_MOTOR_CFG: rdata_r <= {28'h000_0000, motor_cfg_r};
                `MTR_A_IN_FUNC: rdata_r <= in_func_r;
                `MTR_A_OUT_FUNC: rdata_r <= out_func_r;
                `MTR_A_TEMP_LIMIT: rdata_r <= {16'h0000, temp_limit_r};
                `MTR_A_STATUS: rdata_r <= {22'h00_0000, m2_state, m1_state,
                    zone_r, rt, gate_r, pre_r, ttrip_r, mtrip_r};
                `MTR_A_HEAT1: rdata_r <= heat1_r[47:16];
                `MTR_A_HEAT2: rdata_r <= heat2_r[47:16];
                `MTR_A_IRQ_STAT: rdata_r <= {29'h0000_0000, irq_stat_r};
                `MTR_A_IRQ_MASK: rdata_r <= {29'h0000_0000, irq_mask_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign rdata_out = rdata_r;
    assign term_out = term_r;
    assign gate_enable_out = gate_r;
    assign motor_overload_trip_out = mtrip_r;
    assign transistor_overload_trip_out = ttrip_r;
    assign thermal_prealarm_display_out = pre_r;
    assign overload_zone_out = zone_r;
    assign irq_out = irq_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    gate_shutoff_a: assert property ((mtrip_r || ttrip_r) |=> !gate_enable_out)
        else $error("gate still enabled after trip");
    m1_disabled_a: assert property (m1_rated_r == 16'h0000 |-> m1_state == MTR_OFF)
        else $error("motor 1 relay active with zero rating");
    heat_clear_a: assert property (frst_s2_r |=> heat1_r == 0 && heat2_r == 0 && !mtrip_r)
        else $error("heat not cleared by reset input");
    m2_track_a: assert property (rt && m2_range |-> m2_state == MTR_TRACK)
        else $error("motor 2 not tracking under select");
    m1_track_a: assert property (m1_on && !rt |-> m1_state == MTR_TRACK)
        else $error("motor 1 not tracking");
    cool_fall_a: assert property (tick_r && m1_state == MTR_COOL && !frst_s2_r
        |=> heat1_r <= $past(heat1_r))
        else $error("cooling heat rose");
    m2_cool_a: assert property (!rt && m2_range |-> m2_state == MTR_COOL)
        else $error("motor 2 not cooling");
    prealarm_a: assert property (pre_hit && !frst_s2_r |=> thermal_prealarm_display_out)
        else $error("prealarm missing");
    prealarm_drop_a: assert property (!pre_hit |=> !thermal_prealarm_display_out)
        else $error("prealarm held below level");
    motor_trip_a: assert property (trip_hit && !frst_s2_r |=> mtrip_r ##1 !gate_enable_out)
        else $error("motor trip missing");
    term_pos_a: assert property (fn_code(out_func_r, 0) == `MTR_FN_PRE_POS && $stable(out_func_r)
        |=> term_out[0] == $past(pre_r))
        else $error("terminal not following prealarm");
    rt_pick_a: assert property (term_s2_r[0] && fn_code(in_func_r, 0) == `MTR_FN_RT |-> rt)
        else $error("select input ignored");
    temp_trip_a: assert property (temp_hit && !frst_s2_r |=> ttrip_r)
        else $error("transistor trip missing");

    motor_trip_c: cover property (mtrip_r && !$past(mtrip_r));
    prealarm_c: cover property (pre_r ##1 !pre_r);
    rt_swap_c: cover property (rt && m1_state == MTR_COOL && m2_state == MTR_TRACK);
endmodule : mtr_relay
